// ===== logic/fcs_host.sv
// Host controller: takes one operation at a time from the user port and
// runs the flash bus command sequence, polling status where needed.
// Assumes flash bus pins synchronous to ref_clk; one transfer in flight.

`default_nettype none

module fcs_host #(
  parameter int ADDR_W = 22,
  parameter logic [15:0] POLL_LIMIT = 16'hFFFF
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire fcs_pkg::fcs_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [15:0] req_wdata,
  // User answer
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic [7:0] rsp_status,
  output logic rsp_error,
  // Flash pins
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_WR1 = 7'b000_0010,
    ST_WR2 = 7'b000_0100,
    ST_RD = 7'b000_1000,
    ST_GAP = 7'b001_0000,
    ST_CLR = 7'b010_0000,
    ST_DONE = 7'b100_0000
  } fcs_state_t;

  fcs_state_t state_q;
  logic [3:0] cnt_q;
  logic [15:0] poll_q;
  fcs_pkg::fcs_op_t op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0] wdata_q;
  logic [7:0] stat_q;
  logic [15:0] rdata_q;
  logic phase_end;
  logic poll_busy;
  logic need_clear;
  logic [7:0] cmd1;
  // Error bits that only the clear command can drop
  localparam logic [7:0] ERR_MASK = 8'((1 << fcs_pkg::BIT_ERASE_FAIL) |
                                       (1 << fcs_pkg::BIT_PROG_FAIL) |
                                       (1 << fcs_pkg::BIT_SUPPLY_LOW) |
                                       (1 << fcs_pkg::BIT_LOCKED));

  assign phase_end = (cnt_q == fcs_pkg::STROBE_CNT);
  assign req_ready = clk_en && (state_q == ST_IDLE);
  // Ready judged from raw bit 7 alone; reserved bit not masked here
  assign poll_busy = !(flash_dq_in[fcs_pkg::BIT_READY]);
  // Program, erase and resume finish with status check, then clear unless the poll times out
  assign need_clear = (op_q == fcs_pkg::FCS_OP_PROGRAM) ||
                      (op_q == fcs_pkg::FCS_OP_ERASE) ||
                      (op_q == fcs_pkg::FCS_OP_RESUME);

  // First write byte per operation
  always_comb begin
    case (op_q)
      fcs_pkg::FCS_OP_READ: cmd1 = fcs_pkg::CMD_READ_ARRAY;
      fcs_pkg::FCS_OP_PROGRAM: cmd1 = fcs_pkg::CMD_PROG_SETUP;
      fcs_pkg::FCS_OP_ERASE: cmd1 = fcs_pkg::CMD_ERASE_SETUP;
      fcs_pkg::FCS_OP_IDENT: cmd1 = fcs_pkg::CMD_READ_IDENT;
      fcs_pkg::FCS_OP_SUSPEND: cmd1 = fcs_pkg::CMD_SUSPEND;
      fcs_pkg::FCS_OP_RESUME: cmd1 = fcs_pkg::CMD_CONFIRM;
      fcs_pkg::FCS_OP_CLEAR: cmd1 = fcs_pkg::CMD_CLEAR_STATUS;
      fcs_pkg::FCS_OP_STATUS: cmd1 = fcs_pkg::CMD_READ_STATUS;
      default: cmd1 = fcs_pkg::CMD_READ_ARRAY;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Phase counter times each strobe and each gap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (state_q == ST_IDLE || state_q == ST_DONE || phase_end) begin
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Request capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_q <= fcs_pkg::FCS_OP_READ;
      addr_q <= '0;
      wdata_q <= 16'h0000;
    end else if (clk_en && req_valid && state_q == ST_IDLE) begin
      op_q <= req_op;
      // Identifier reads use only bit 0, higher bits zero
      if (req_op == fcs_pkg::FCS_OP_IDENT) begin
        addr_q <= {{(ADDR_W-1){1'b0}}, req_addr[0]};
      end else begin
        addr_q <= req_addr;
      end
      wdata_q <= req_wdata;
    end
  end

  // State walk
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      poll_q <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          poll_q <= 16'h0000;
          if (req_valid) begin
            state_q <= ST_WR1;
          end
        end
        ST_WR1: begin
          if (phase_end) begin
            case (op_q)
              fcs_pkg::FCS_OP_PROGRAM, fcs_pkg::FCS_OP_ERASE:
                state_q <= ST_WR2;
              fcs_pkg::FCS_OP_SUSPEND, fcs_pkg::FCS_OP_CLEAR:
                state_q <= ST_DONE;
              default: state_q <= ST_GAP;
            endcase
          end
        end
        ST_WR2: begin
          if (phase_end) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (phase_end) begin
            state_q <= ST_RD;
          end
        end
        ST_RD: begin
          if (phase_end) begin
            // Each poll is a fresh strobe, so completion is seen
            if (need_clear && poll_busy && poll_q != POLL_LIMIT) begin
              poll_q <= poll_q + 16'h0001;
              state_q <= ST_GAP;
            end else if (need_clear && !poll_busy) begin
              state_q <= ST_CLR;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_CLR: begin
          if (phase_end) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Read sampling and status masking
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_q <= 8'h80;
      rdata_q <= 16'h0000;
    end else if (clk_en && state_q == ST_RD && phase_end) begin
      rdata_q <= flash_dq_in;
      stat_q <= flash_dq_in[7:0] & fcs_pkg::STATUS_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Resume holds chip select low through the poll loop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
    end else if (clk_en) begin
      flash_ce_n <= (state_q == ST_IDLE) || (state_q == ST_DONE);
      flash_we_n <= !((state_q == ST_WR1 || state_q == ST_WR2 ||
                       state_q == ST_CLR) && !phase_end);
      flash_oe_n <= !(state_q == ST_RD && !phase_end);
      flash_addr <= (state_q == ST_WR2 || state_q == ST_RD) ?
                    addr_q : '0;
      // Upper byte driven low on command writes
      if (state_q == ST_WR2 && op_q == fcs_pkg::FCS_OP_PROGRAM) begin
        flash_dq_out <= wdata_q;
      end else if (state_q == ST_WR2) begin
        flash_dq_out <= {8'h00, fcs_pkg::CMD_CONFIRM};
      end else if (state_q == ST_CLR) begin
        flash_dq_out <= {8'h00, fcs_pkg::CMD_CLEAR_STATUS};
      end else begin
        flash_dq_out <= {8'h00, cmd1};
      end
      flash_dq_oe_n <= !(state_q == ST_WR1 || state_q == ST_WR2 ||
                         state_q == ST_CLR);
    end
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  assign rsp_valid = clk_en && (state_q == ST_DONE);
  assign rsp_rdata = rdata_q;
  assign rsp_status = stat_q;
  // On program, erase or resume, any error bit or a timed-out poll marks failure
  assign rsp_error = need_clear &&
                     ((stat_q & ERR_MASK) != 8'h00 ||
                      !stat_q[fcs_pkg::BIT_READY]);

  // Status word never shows the reserved bit
  property p_mask;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(rsp_valid) |-> !rsp_status[0];
  endproperty
  a_mask: assert property (p_mask) else $error("reserved bit seen");

  // Strobes never overlap
  property p_no_overlap;
    @(posedge ref_clk) disable iff (!rst_n)
      !(!flash_we_n && !flash_oe_n);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("oe and we both low");

  // Upper byte zero on command writes
  property p_upper;
    @(posedge ref_clk) disable iff (!rst_n)
      (!flash_we_n && op_q != fcs_pkg::FCS_OP_PROGRAM)
        |-> flash_dq_out[15:8] == 8'h00 && !flash_dq_oe_n;
  endproperty
  a_upper: assert property (p_upper) else $error("upper byte bad");

  // Read strobe only with chip select low
  property p_ce_rd;
    @(posedge ref_clk) disable iff (!rst_n)
      !flash_oe_n |-> !flash_ce_n;
  endproperty
  a_ce_rd: assert property (p_ce_rd) else $error("oe without ce");

  // Write strobe only with chip select low, else the write is lost
  property p_ce_wr;
    @(posedge ref_clk) disable iff (!rst_n)
      !flash_we_n |-> !flash_ce_n;
  endproperty
  a_ce_wr: assert property (p_ce_wr) else $error("we without ce");

  // On program, erase or resume, a final status still busy is never reported as success
  property p_busy_err;
    @(posedge ref_clk) disable iff (!rst_n)
      (rsp_valid && need_clear && !rsp_status[fcs_pkg::BIT_READY])
        |-> rsp_error;
  endproperty
  a_busy_err: assert property (p_busy_err) else $error("busy ok");

endmodule

`default_nettype wire

// ===== logic/fcs_pkg.sv
// Constants for the host-side flash command and status controller.
// Assumes a parallel NOR flash with 16-bit data and byte-wide commands.
//
// Overview of operation
// - After resumed erase, read then clear status before next command; the host skips the clear when its poll times out.
// - Block erase writes 20H anywhere, then D0H inside the block.
// - FFH array read, 50H clear status, B0H suspend, D0H resume.
// - 70H makes later reads return status at any address.
// - Program writes 40H (or 10H) setup, then address and data word.
// - After 90H, address bit 0 picks maker or device code; rest zero.
// - Host drives upper data byte to valid levels on command writes.
// - Status bit 7 is ready; check it before result bits.
// - Status bit 0 is reserved and masked by the host; rsp_rdata still carries it raw.
// - Status latched on strobe fall; host toggles strobe every poll.

`default_nettype none

package fcs_pkg;
  // Command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  // Status bit positions
  localparam int BIT_READY = 7;
  localparam int BIT_ERASE_SUSP = 6;
  localparam int BIT_ERASE_FAIL = 5;
  localparam int BIT_PROG_FAIL = 4;
  localparam int BIT_SUPPLY_LOW = 3;
  localparam int BIT_PROG_SUSP = 2;
  localparam int BIT_LOCKED = 1;
  // Reserved bit 0 masked off every status sample
  localparam logic [7:0] STATUS_MASK = 8'hFE;
  // Bus timing in clock cycles, each phase at least one cycle
  localparam int STROBE_NS = 80;
  localparam int CLK_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  // User operation codes
  typedef enum logic [2:0] {
    FCS_OP_READ = 3'h0,
    FCS_OP_PROGRAM = 3'h1,
    FCS_OP_ERASE = 3'h2,
    FCS_OP_IDENT = 3'h3,
    FCS_OP_SUSPEND = 3'h4,
    FCS_OP_RESUME = 3'h5,
    FCS_OP_CLEAR = 3'h6,
    FCS_OP_STATUS = 3'h7
  } fcs_op_t;
endpackage

`default_nettype wire

// ===== bench/fcs_flash_model.sv
// Behavioural flash device: command decode, busy timer and status byte.
// Assumes host pins change on ref_clk; faults come from bench inputs.
`default_nettype none
module fcs_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A1, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h00B2, // Arbitrary value
  parameter logic [7:0] PROG_CYC = 8'h0F,
  parameter logic [7:0] ERASE_CYC = 8'h46
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Flash pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  // Fault injection
  input wire logic inj_fail,
  input wire logic inj_low,
  input wire logic inj_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr_q, busy_q, cmd;
  logic [1:0] mode_q, pend_q;
  logic erase_q, oe_q, we_q;
  logic [15:0] lat_q;
  // Last word that really started programming, read back from the array
  logic [21:0] pw_addr_q;
  logic [15:0] pw_data_q;
  assign cmd = dq_out[7:0];
  // ----------------------------------------
  // Command decode and operation timer
  // ----------------------------------------
  // Reserved bit 0 reads 1, so a host that forgets the mask shows it
  always_ff @(posedge ref_clk) begin
    oe_q <= oe_n;
    we_q <= we_n;
    if (!rst_n) begin
      sr_q <= 8'h81;
      mode_q <= 2'h0;
      pend_q <= 2'h0;
      busy_q <= 8'h00;
      erase_q <= 1'b0;
      pw_addr_q <= '1;
      pw_data_q <= 16'h0000;
    end else if (!we_q && we_n && !ce_n) begin
      mode_q <= 2'h1;
      pend_q <= 2'h0;
      if (pend_q != 2'h0) begin
        if (inj_lock) sr_q <= sr_q | 8'h02;
        else if (inj_low) sr_q <= sr_q | {2'h0, pend_q[1], 5'h08};
        else if (pend_q[1] && cmd != 8'hD0) sr_q <= sr_q | 8'h30;
        else begin
          busy_q <= pend_q[1] ? ERASE_CYC : PROG_CYC;
          sr_q[7] <= 1'b0;
          erase_q <= pend_q[1];
          if (!pend_q[1]) begin
            pw_addr_q <= addr;
            pw_data_q <= dq_out;
          end
        end
      end else begin
        case (cmd)
        8'hFF: mode_q <= 2'h0;
        8'h90: mode_q <= 2'h2;
        8'h50: sr_q <= sr_q & 8'hC5;
        8'h40, 8'h10: pend_q <= 2'h1;
        8'h20: pend_q <= 2'h2;
        8'hB0: if (busy_q != 8'h00) sr_q <= sr_q | (erase_q ? 8'hC0 : 8'h84);
        8'hD0: if (sr_q[6] | sr_q[2]) sr_q <= sr_q & 8'h3B;
        default: ;
        endcase
      end
    end else if (busy_q != 8'h00 && !sr_q[7] && !ce_n) begin
      // Work only advances while selected and not suspended
      busy_q <= busy_q - 8'h01;
      if (busy_q == 8'h01) begin
        sr_q[7] <= 1'b1;
        if (inj_fail) sr_q[erase_q ? 5 : 4] <= 1'b1;
        if (inj_low) sr_q[3] <= 1'b1;
      end
    end
  end
  // Output latched at the strobe fall so one poll sees one value
  always_ff @(posedge ref_clk) begin
    if (oe_q && !oe_n && !ce_n) begin
      case (mode_q)
      2'h1: lat_q <= {8'h00, sr_q};
      2'h2: lat_q <= (addr[21:1] != 21'h0) ? 16'h0000 :
        (addr[0] ? PART_CODE : MAKER_CODE);
      default: lat_q <= (addr == pw_addr_q) ? pw_data_q : ~addr[15:0];
      endcase
    end
  end
  // Released bus shows the inverse, so a late sample is caught
  assign dq_in = (!ce_n && !oe_n) ? lat_q : ~lat_q;
endmodule
`default_nettype wire

// ===== bench/fcs_host_bench.sv
// Bench for the flash host controller against a device model.
// Assumes model and controller share ref_clk; poll limit set to 4.
`default_nettype none
module fcs_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MAKER = 16'h00A1; // Arbitrary value
  localparam logic [15:0] PART = 16'h00B2; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic inj_fail = 1'b0;
  logic inj_low = 1'b0;
  logic inj_lock = 1'b0;
  fcs_pkg::fcs_op_t req_op = fcs_pkg::FCS_OP_READ;
  logic [21:0] req_addr = 22'h00_0000;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, rsp_valid, rsp_error, ce_n, oe_n, we_n, dq_oe_n;
  logic [21:0] f_addr;
  logic [15:0] rdata, dq_out, dq_in;
  logic [7:0] status;
  int n_mismatch = 0;
  int n_tests = 0;
  // ----------------------------------------
  // Clock, design and device
  // ----------------------------------------
  always #10 ref_clk = ~ref_clk;
  fcs_host #(.ADDR_W(22), .POLL_LIMIT(16'h0004)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rdata), .rsp_status(status), .rsp_error(rsp_error),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(f_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
    .flash_dq_oe_n(dq_oe_n));
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(f_addr), .dq_out(dq_out), .dq_in(dq_in),
    .inj_fail(inj_fail), .inj_low(inj_low), .inj_lock(inj_lock));
  // Request held until the edge that sees ready, then one answer
  task automatic run(fcs_pkg::fcs_op_t op, logic [21:0] a, logic [15:0] w);
    int n;
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_wdata <= w;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (n = 0; n < 2000 && rsp_valid !== 1'b1; n++) @(posedge ref_clk);
    // A missing answer counts as a mismatch
    if (n == 2000) chk({15'h0000, rsp_valid}, 16'h0001);
  endtask
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic res(logic e, logic [7:0] s);
    chk({7'h00, rsp_error, status}, {7'h00, e, s});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({12'h000, ce_n, oe_n, we_n, dq_oe_n}, 16'h000F);
    chk({8'h00, status}, 16'h0080);
    clk_en <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk({15'h0000, req_ready}, 16'h0000);
    clk_en <= 1'b1;
  endtask
  task automatic t_reads;
    run(fcs_pkg::FCS_OP_STATUS, 22'h3F_FFFF, 16'h0000);
    chk(rdata, 16'h0081);
    chk({8'h00, status}, 16'h0080);
    run(fcs_pkg::FCS_OP_IDENT, 22'h2A_AAA0, 16'h0000);
    chk(rdata, MAKER);
    run(fcs_pkg::FCS_OP_IDENT, 22'h15_5555, 16'h0000);
    chk(rdata, PART);
    run(fcs_pkg::FCS_OP_READ, 22'h00_1234, 16'h0000);
    chk(rdata, 16'hEDCB);
  endtask
  task automatic t_faults;
    run(fcs_pkg::FCS_OP_PROGRAM, 22'h00_0010, 16'h1234);
    res(1'b0, 8'h80);
    inj_fail <= 1'b1;
    run(fcs_pkg::FCS_OP_PROGRAM, 22'h00_0010, 16'h1234);
    res(1'b1, 8'h90);
    inj_fail <= 1'b0;
    run(fcs_pkg::FCS_OP_STATUS, 22'h00_0000, 16'h0000);
    chk(rdata, 16'h0081);
    inj_lock <= 1'b1;
    run(fcs_pkg::FCS_OP_ERASE, 22'h00_0000, 16'h0000);
    res(1'b1, 8'h82);
    inj_lock <= 1'b0;
    inj_low <= 1'b1;
    run(fcs_pkg::FCS_OP_ERASE, 22'h00_0000, 16'h0000);
    res(1'b1, 8'hA8);
    run(fcs_pkg::FCS_OP_PROGRAM, 22'h00_0020, 16'h00FF);
    res(1'b1, 8'h88);
    inj_low <= 1'b0;
    run(fcs_pkg::FCS_OP_READ, 22'h00_0010, 16'h0000);
    chk(rdata, 16'h1234);
    run(fcs_pkg::FCS_OP_READ, 22'h00_0020, 16'h0000);
    chk(rdata, 16'hFFDF);
  endtask
  // Mid-run reset brings back ready status in host and device
  task automatic t_rerst;
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({8'h00, status}, 16'h0080);
    run(fcs_pkg::FCS_OP_STATUS, 22'h00_0000, 16'h0000);
    chk(rdata, 16'h0081);
  endtask
  task automatic t_suspend;
    run(fcs_pkg::FCS_OP_ERASE, 22'h01_0000, 16'h0000);
    res(1'b1, 8'h00);
    run(fcs_pkg::FCS_OP_SUSPEND, 22'h00_0000, 16'h0000);
    run(fcs_pkg::FCS_OP_STATUS, 22'h00_0000, 16'h0000);
    chk(rdata, 16'h00C1);
    inj_fail <= 1'b1;
    run(fcs_pkg::FCS_OP_RESUME, 22'h00_0000, 16'h0000);
    res(1'b1, 8'hA0);
    inj_fail <= 1'b0;
    run(fcs_pkg::FCS_OP_STATUS, 22'h00_0000, 16'h0000);
    chk(rdata, 16'h0081);
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence and hang guard
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_reads();
    t_faults();
    t_rerst();
    t_suspend();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
